// >>> verilog/cpm_mode_ctl.sv
// Mode and setting decode for the converter and output paths.
// Assumes a register port synchronous to core_clk and a DSP clip pulse.
//
// What this block does
// - Two-bit DAC highpass select: bypass, low, middle, high band.
// - Left and right ADC enables from converter enable bits five, four.
// - Digital clipping sets the clip flag in status bit seven.
// - All digital logic runs from one master clock the system supplies.
// - Filter bit five adds voice highpass to recorded data.
// - Filter bit four adds voice highpass to primary playback data.
// - Voice filters only in voice mode; playback side primary only.
// - Voice passband doubles in 16 kHz voice mode.
// - Two line-input gains from their own registers, 2 dB steps.
// - Headphone mode field: stereo, balanced mono, single-ended mono.
// - Balanced mono bridges right amp; single-ended uses left; both sum.
// - Mode 111 turns headphones off and the summing receiver on.
// - Independent left and right headphone gain registers.
// - Speaker field 11 enables both speakers, 10 left, 01 right, 00 neither.
// - Left and right speaker gain from six-bit fields.
// - Line variant: field 11 enables both differential line outputs.
// - Line variant: six-bit left and right line output gains.
// - Format codes 0xa and 0xb mean 8 and 16 kHz voice.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module cpm_mode_ctl
  import cpm_pkg::*;
#(
  parameter bit LINE_VARIANT = 1'b0,
  parameter int VOL_INIT_CYC = CPM_VOL_INIT_CYC,
  parameter int SW_DIV       = CPM_SW_DIV
)
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  input  wire logic                 clip_event,
  output logic                      digital_clip_flag,
  output logic      [1:0]           left_dac_highpass_select,
  output logic      [1:0]           right_dac_highpass_select,
  output logic      [2:0]           left_dac_hp_band,
  output logic      [2:0]           right_dac_hp_band,
  output logic                      left_adc_enable,
  output logic                      right_adc_enable,
  output logic                      record_voice_hp_on,
  output logic                      playback_voice_hp_on,
  output logic                      voice_band_wide,
  output logic      [CPM_LIN_W-1:0] line_input_one_gain,
  output logic      [CPM_LIN_W-1:0] line_input_two_gain,
  output logic                      hp_left_on,
  output logic                      hp_right_on,
  output logic                      hp_bridged,
  output logic                      hp_mono_sum,
  output logic                      receiver_on,
  output logic [CPM_GAIN_W-1:0]     headphone_left_gain,
  output logic [CPM_GAIN_W-1:0]     headphone_right_gain,
  output logic                      speaker_left_on,
  output logic                      speaker_right_on,
  output logic                      switch_tick,
  output logic [CPM_GAIN_W-1:0]     speaker_left_gain,
  output logic [CPM_GAIN_W-1:0]     speaker_right_gain,
  output logic                      line_out_left_on,
  output logic                      line_out_right_on,
  output logic [CPM_GAIN_W-1:0]     line_output_left_gain,
  output logic [CPM_GAIN_W-1:0]     line_output_right_gain,
  output logic                      vol_init_done
);

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [2:0] hp_decode(input logic [1:0] sel);
    hp_decode = 3'h0;
    unique case (sel)
      CPM_HP_BYPASS: hp_decode = 3'h0;
      CPM_HP_LOW:    hp_decode = 3'h1;
      CPM_HP_MID:    hp_decode = 3'h2;
      CPM_HP_HIGH:   hp_decode = 3'h4;
    endcase
  endfunction

  function automatic logic is_voice(input logic [3:0] fmt);
    is_voice = (fmt == CPM_FMT_VOICE8) || (fmt == CPM_FMT_VOICE16);
  endfunction

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic                  clip_r;
  logic [3:0]            fmt1_r;
  logic [3:0]            fmt2_r;
  logic [5:0]            filt_r;
  logic [CPM_LIN_W-1:0]  lin1_r;
  logic [CPM_LIN_W-1:0]  lin2_r;
  logic [CPM_GAIN_W-1:0] hpl_r;
  logic [CPM_GAIN_W-1:0] hpr_r;
  logic [CPM_GAIN_W-1:0] spl_r;
  logic [CPM_GAIN_W-1:0] spr_r;
  logic [4:0]            omode_r;
  logic                  swclk_r;
  logic [7:0]            conv_r;
  logic [7:0]            rdata_r;
  logic [7:0]            rdata_nxt;

  cpm_ctl_if ctl ();

  function automatic logic hit(input logic [7:0] ofs);
    hit = reg_wr && (reg_addr == ofs);
  endfunction

  // The clip flag is sticky; writing one clears it, but a new clip wins.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clip_r <= 1'b0;
    end else if (clip_event) begin
      clip_r <= 1'b1;
    end else if (hit(CPM_STATUS_OFS) && reg_wdata[CPM_CLIP_BIT]) begin
      clip_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fmt1_r <= CPM_RST_VAL[3:0];
      fmt2_r <= CPM_RST_VAL[3:0];
      filt_r <= CPM_RST_VAL[5:0];
      conv_r <= CPM_RST_VAL;
    end else begin
      if (hit(CPM_FMT1_OFS)) fmt1_r <= reg_wdata[3:0];
      if (hit(CPM_FMT2_OFS)) fmt2_r <= reg_wdata[3:0];
      if (hit(CPM_FILT_OFS)) filt_r <= reg_wdata[5:0];
      if (hit(CPM_CONV_OFS)) conv_r <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lin1_r  <= CPM_RST_VAL[CPM_LIN_W-1:0];
      lin2_r  <= CPM_RST_VAL[CPM_LIN_W-1:0];
      hpl_r   <= CPM_RST_VAL[CPM_GAIN_W-1:0];
      hpr_r   <= CPM_RST_VAL[CPM_GAIN_W-1:0];
      spl_r   <= CPM_RST_VAL[CPM_GAIN_W-1:0];
      spr_r   <= CPM_RST_VAL[CPM_GAIN_W-1:0];
      omode_r <= CPM_RST_VAL[4:0];
      swclk_r <= 1'b0;
    end else begin
      if (hit(CPM_LIN1_OFS)) lin1_r <= reg_wdata[CPM_LIN_W-1:0];
      if (hit(CPM_LIN2_OFS)) lin2_r <= reg_wdata[CPM_LIN_W-1:0];
      if (hit(CPM_HPL_OFS)) hpl_r <= reg_wdata[CPM_GAIN_W-1:0];
      if (hit(CPM_HPR_OFS)) hpr_r <= reg_wdata[CPM_GAIN_W-1:0];
      // One pair of gain registers serves speakers or line outputs.
      if (hit(CPM_SPL_OFS)) spl_r <= reg_wdata[CPM_GAIN_W-1:0];
      if (hit(CPM_SPR_OFS)) spr_r <= reg_wdata[CPM_GAIN_W-1:0];
      if (hit(CPM_OMODE_OFS)) omode_r <= reg_wdata[4:0];
      if (hit(CPM_PWR_OFS)) swclk_r <= reg_wdata[CPM_SWCLK_BIT];
    end
  end

  // ***************************************************************
  // Read port
  // ***************************************************************
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      CPM_STATUS_OFS: rdata_nxt = {clip_r, 7'h00};
      CPM_FMT1_OFS:   rdata_nxt = {4'h0, fmt1_r};
      CPM_FMT2_OFS:   rdata_nxt = {4'h0, fmt2_r};
      CPM_FILT_OFS:   rdata_nxt = {2'h0, filt_r};
      CPM_LIN1_OFS:   rdata_nxt = {3'h0, lin1_r};
      CPM_LIN2_OFS:   rdata_nxt = {3'h0, lin2_r};
      CPM_HPL_OFS:    rdata_nxt = {2'h0, hpl_r};
      CPM_HPR_OFS:    rdata_nxt = {2'h0, hpr_r};
      CPM_SPL_OFS:    rdata_nxt = {2'h0, spl_r};
      CPM_SPR_OFS:    rdata_nxt = {2'h0, spr_r};
      CPM_OMODE_OFS:  rdata_nxt = {3'h0, omode_r};
      CPM_PWR_OFS:    rdata_nxt = {7'h00, swclk_r};
      CPM_CONV_OFS:   rdata_nxt = conv_r;
      default:        rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

  // ***************************************************************
  // Path decode
  // ***************************************************************
  logic v1;
  logic v2;
  assign v1 = is_voice(fmt1_r);
  assign v2 = is_voice(fmt2_r);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      left_dac_hp_band     <= 3'h0;
      right_dac_hp_band    <= 3'h0;
      left_adc_enable      <= 1'b0;
      right_adc_enable     <= 1'b0;
      record_voice_hp_on   <= 1'b0;
      playback_voice_hp_on <= 1'b0;
      voice_band_wide      <= 1'b0;
    end else begin
      left_dac_hp_band  <= hp_decode(filt_r[3:2]);
      right_dac_hp_band <= hp_decode(filt_r[1:0]);
      left_adc_enable   <= conv_r[CPM_ADCL_BIT];
      right_adc_enable  <= conv_r[CPM_ADCR_BIT];
      // Record filtering follows whichever port is in voice mode.
      record_voice_hp_on <= filt_r[CPM_REC_HP_BIT] && (v1 || v2);
      // Playback filtering exists only on the primary port.
      playback_voice_hp_on <= filt_r[CPM_PLAY_HP_BIT] && v1;
      voice_band_wide <= (v1 && fmt1_r == CPM_FMT_VOICE16) ||
                         (!v1 && fmt2_r == CPM_FMT_VOICE16);
    end
  end

  assign ctl.hr_mode      = omode_r[2:0];
  assign ctl.out_mode     = omode_r[4:3];
  assign ctl.line_variant = LINE_VARIANT;
  // The divider runs only while a speaker is on and the bit is set.
  assign ctl.sw_run = swclk_r && !LINE_VARIANT &&
                      (omode_r[4:3] != 2'h0);

  cpm_out_decode u_dec (
    .c (ctl.dec)
  );

  // The switching pulse is derived from the one core clock.
  cpm_sw_div #(
    .DIV (SW_DIV)
  ) u_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .c        (ctl.div)
  );

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hp_left_on        <= 1'b0;
      hp_right_on       <= 1'b0;
      hp_bridged        <= 1'b0;
      hp_mono_sum       <= 1'b0;
      receiver_on       <= 1'b0;
      speaker_left_on   <= 1'b0;
      speaker_right_on  <= 1'b0;
      line_out_left_on  <= 1'b0;
      line_out_right_on <= 1'b0;
      switch_tick       <= 1'b0;
    end else begin
      hp_left_on        <= ctl.hp_l_en;
      hp_right_on       <= ctl.hp_r_en;
      hp_bridged        <= ctl.hp_bridge;
      hp_mono_sum       <= ctl.hp_sum;
      receiver_on       <= ctl.rcv_en;
      speaker_left_on   <= ctl.spk_l_en;
      speaker_right_on  <= ctl.spk_r_en;
      line_out_left_on  <= ctl.lo_l_en;
      line_out_right_on <= ctl.lo_r_en;
      switch_tick       <= ctl.sw_tick;
    end
  end

  // Volume circuitry needs a stretch of running clock after power-on.
  localparam int VW = $clog2(VOL_INIT_CYC + 1);
  logic [VW-1:0] vol_cnt_r;
  logic          vol_done_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      vol_cnt_r  <= '0;
      vol_done_r <= 1'b0;
    end else if (!vol_done_r) begin
      vol_cnt_r  <= vol_cnt_r + 1'b1;
      vol_done_r <= (vol_cnt_r == VW'(VOL_INIT_CYC - 1));
    end
  end

  assign reg_rdata                 = rdata_r;
  assign digital_clip_flag         = clip_r;
  assign left_dac_highpass_select  = filt_r[3:2];
  assign right_dac_highpass_select = filt_r[1:0];
  assign line_input_one_gain       = lin1_r;
  assign line_input_two_gain       = lin2_r;
  assign headphone_left_gain       = hpl_r;
  assign headphone_right_gain      = hpr_r;
  assign speaker_left_gain         = spl_r;
  assign speaker_right_gain        = spr_r;
  assign line_output_left_gain     = spl_r;
  assign line_output_right_gain    = spr_r;
  assign vol_init_done             = vol_done_r;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // The divide ratio is a parameter, so pulse spacing is counted here
  // rather than unrolled in a repetition.
  localparam int GW = $clog2(SW_DIV + 1);
  logic [GW-1:0] tick_gap_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_gap_r <= '1;
    end else if (switch_tick) begin
      tick_gap_r <= '0;
    end else if (tick_gap_r != '1) begin
      tick_gap_r <= tick_gap_r + 1'b1;
    end
  end

  clip_set_a: assert property (clip_event |=> digital_clip_flag)
    else $error("clip event did not set the flag");
  adc_enable_a: assert property (
    reg_wr && reg_addr == CPM_CONV_OFS |=> ##1
      left_adc_enable == $past(reg_wdata[CPM_ADCL_BIT], 2) &&
      right_adc_enable == $past(reg_wdata[CPM_ADCR_BIT], 2))
    else $error("adc enables do not follow the register");
  dac_band_a: assert property (
    reg_wr && reg_addr == CPM_FILT_OFS && reg_wdata[3:2] == CPM_HP_HIGH
      |=> ##1 left_dac_hp_band == 3'h4)
    else $error("left dac band not high");
  play_filter_a: assert property (
    playback_voice_hp_on |-> $past(v1))
    else $error("playback filter outside primary voice mode");
  hp_stereo_a: assert property (
    ctl.hr_mode == CPM_HR_STEREO |=>
      hp_left_on && hp_right_on && !receiver_on && !hp_mono_sum)
    else $error("stereo headphone decode wrong");
  hp_bridge_a: assert property (
    ctl.hr_mode == CPM_HR_BRIDGE |=>
      hp_bridged && hp_right_on && hp_mono_sum)
    else $error("bridged mono decode wrong");
  receiver_sel_a: assert property (
    ctl.hr_mode == CPM_HR_RCV |=>
      receiver_on && !hp_left_on && !hp_right_on)
    else $error("receiver mode decode wrong");
  spk_both_a: assert property (
    !LINE_VARIANT && ctl.out_mode == CPM_OUT_BOTH |=>
      speaker_left_on && speaker_right_on)
    else $error("speakers not both on");
  sw_spacing_a: assert property (
    switch_tick |-> tick_gap_r >= GW'(SW_DIV - 1))
    else $error("switching pulses too close");
  wide_band_a: assert property (
    fmt1_r == CPM_FMT_VOICE16 |=> voice_band_wide)
    else $error("16 kHz voice did not widen passband");

endmodule

// >>> verilog/cpm_pkg.sv
// Constants shared by the codec path mode control block.
// Assumes an 8-bit register port and one 100 MHz core clock.
package cpm_pkg;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] CPM_STATUS_OFS   = 8'h00;
  localparam logic [7:0] CPM_FMT1_OFS     = 8'h03;
  localparam logic [7:0] CPM_FMT2_OFS     = 8'h05;
  localparam logic [7:0] CPM_FILT_OFS     = 8'h07;
  localparam logic [7:0] CPM_LIN1_OFS     = 8'h0e;
  localparam logic [7:0] CPM_LIN2_OFS     = 8'h0f;
  localparam logic [7:0] CPM_HPL_OFS      = 8'h14;
  localparam logic [7:0] CPM_HPR_OFS      = 8'h15;
  localparam logic [7:0] CPM_SPL_OFS      = 8'h16;
  localparam logic [7:0] CPM_SPR_OFS      = 8'h17;
  localparam logic [7:0] CPM_OMODE_OFS    = 8'h18;
  localparam logic [7:0] CPM_PWR_OFS      = 8'h1a;
  localparam logic [7:0] CPM_CONV_OFS     = 8'h1b;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int CPM_CLIP_BIT    = 7;
  localparam int CPM_REC_HP_BIT  = 5;
  localparam int CPM_PLAY_HP_BIT = 4;
  localparam int CPM_ADCL_BIT    = 5;
  localparam int CPM_ADCR_BIT    = 4;
  localparam int CPM_SWCLK_BIT   = 0;
  localparam int CPM_GAIN_W      = 6;
  localparam int CPM_LIN_W       = 5;
  localparam logic [7:0] CPM_RST_VAL = 8'h00;

  // ***************************************************************
  // Mode encodings
  // ***************************************************************
  localparam logic [1:0] CPM_HP_BYPASS  = 2'h0;
  localparam logic [1:0] CPM_HP_LOW     = 2'h1;
  localparam logic [1:0] CPM_HP_MID     = 2'h2;
  localparam logic [1:0] CPM_HP_HIGH    = 2'h3;
  localparam logic [3:0] CPM_FMT_VOICE8  = 4'ha;
  localparam logic [3:0] CPM_FMT_VOICE16 = 4'hb;
  localparam logic [2:0] CPM_HR_STEREO  = 3'h4;
  localparam logic [2:0] CPM_HR_SEMONO  = 3'h5;
  localparam logic [2:0] CPM_HR_BRIDGE  = 3'h6;
  localparam logic [2:0] CPM_HR_RCV     = 3'h7;
  localparam logic [1:0] CPM_OUT_BOTH   = 2'h3;
  localparam logic [1:0] CPM_OUT_LEFT   = 2'h2;
  localparam logic [1:0] CPM_OUT_RIGHT  = 2'h1;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CPM_CORE_KHZ     = 100000;
  localparam int CPM_SW_KHZ       = 1100;
  localparam int CPM_SW_DIV       = CPM_CORE_KHZ / CPM_SW_KHZ;
  localparam int CPM_VOL_INIT_US  = 1000;
  localparam int CPM_VOL_INIT_CYC = CPM_VOL_INIT_US * (CPM_CORE_KHZ / 1000) + 1;

endpackage

// >>> verilog/cpm_ctl_if.sv
// Carrier between the mode control top and its two helper modules.
// Assumes all members change on core_clk in the top module.
`timescale 1ns/1ps
interface cpm_ctl_if;
  logic [2:0] hr_mode;
  logic [1:0] out_mode;
  logic       line_variant;
  logic       sw_run;
  logic       sw_tick;
  logic       hp_l_en;
  logic       hp_r_en;
  logic       hp_bridge;
  logic       hp_sum;
  logic       rcv_en;
  logic       spk_l_en;
  logic       spk_r_en;
  logic       lo_l_en;
  logic       lo_r_en;

  modport top (output hr_mode, out_mode, line_variant, sw_run,
               input  sw_tick, hp_l_en, hp_r_en, hp_bridge, hp_sum,
                      rcv_en, spk_l_en, spk_r_en, lo_l_en, lo_r_en);
  modport dec (input  hr_mode, out_mode, line_variant,
               output hp_l_en, hp_r_en, hp_bridge, hp_sum, rcv_en,
                      spk_l_en, spk_r_en, lo_l_en, lo_r_en);
  modport div (input sw_run, output sw_tick);
endinterface

// >>> verilog/cpm_out_decode.sv
// Output amplifier mode decode, purely combinational.
// Assumes the top registers every result before it leaves the block.
`timescale 1ns/1ps
module cpm_out_decode
  import cpm_pkg::*;
(
  cpm_ctl_if.dec c
);

  always_comb begin
    c.hp_l_en   = 1'b0;
    c.hp_r_en   = 1'b0;
    c.hp_bridge = 1'b0;
    c.hp_sum    = 1'b0;
    c.rcv_en    = 1'b0;
    unique case (c.hr_mode)
      CPM_HR_STEREO: begin
        c.hp_l_en = 1'b1;
        c.hp_r_en = 1'b1;
      end
      CPM_HR_BRIDGE: begin
        c.hp_l_en   = 1'b1;
        c.hp_r_en   = 1'b1;
        c.hp_bridge = 1'b1;
        c.hp_sum    = 1'b1;
      end
      CPM_HR_SEMONO: begin
        c.hp_l_en = 1'b1;
        c.hp_sum  = 1'b1;
      end
      CPM_HR_RCV: begin
        c.rcv_en = 1'b1;
        c.hp_sum = 1'b1;
      end
      default: begin
        c.hp_l_en = 1'b0;
      end
    endcase
  end

  // Speaker and line outputs share one field; the variant picks the user.
  always_comb begin
    c.spk_l_en = !c.line_variant && (c.out_mode == CPM_OUT_BOTH ||
                                     c.out_mode == CPM_OUT_LEFT);
    c.spk_r_en = !c.line_variant && (c.out_mode == CPM_OUT_BOTH ||
                                     c.out_mode == CPM_OUT_RIGHT);
    c.lo_l_en  = c.line_variant && (c.out_mode == CPM_OUT_BOTH);
    c.lo_r_en  = c.line_variant && (c.out_mode == CPM_OUT_BOTH);
  end

endmodule

// >>> verilog/cpm_sw_div.sv
// Divider that makes the speaker switching enable pulse.
// Assumes sw_run is a level decoded from top registers.
`timescale 1ns/1ps
module cpm_sw_div
  import cpm_pkg::*;
#(
  parameter int DIV = CPM_SW_DIV
)
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  cpm_ctl_if.div    c
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;
  logic          tick_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (!c.sw_run) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (cnt_r == LAST);
      cnt_r  <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end

  assign c.sw_tick = tick_r;

endmodule

// >>> verification/cpm_host_model.sv
// Host model that owns the register port of the mode control block.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module cpm_host_model (
  input  wire logic       core_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // ****************************************
  // Bus cycles
  // ****************************************
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released lines show the inverse so stale values cannot pass.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the codec path mode control block.
// Assumes the speaker variant with short init and divider counts.
`timescale 1ns/1ps
module testbench;
  import cpm_pkg::*;
  // ****************************************
  // Wiring
  // ****************************************
  logic core_clk, rst_b, clip_event, wr, rd, clip_f, adl, adr, rvh, pvh;
  logic vbw, hp_l, hp_r, hb, hs, rcv, spl, spr, tick, lol, lor, vdone;
  logic [7:0] ra, wd, rdt, rv;
  logic [1:0] hsl, hsr;
  logic [2:0] bl, br;
  logic [4:0] li1, li2;
  logic [5:0] hgl, hgr, sgl, sgr, lgl, lgr;
  int mismatches = 0;
  int check_count = 0;

  cpm_host_model host (.core_clk(core_clk), .reg_addr(ra), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdt));

  cpm_mode_ctl #(.LINE_VARIANT(1'b0), .VOL_INIT_CYC(20), .SW_DIV(4)) DUT (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(ra), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdt), .clip_event(clip_event),
    .digital_clip_flag(clip_f), .left_dac_highpass_select(hsl),
    .right_dac_highpass_select(hsr), .left_dac_hp_band(bl),
    .right_dac_hp_band(br), .left_adc_enable(adl), .right_adc_enable(adr),
    .record_voice_hp_on(rvh), .playback_voice_hp_on(pvh),
    .voice_band_wide(vbw), .line_input_one_gain(li1),
    .line_input_two_gain(li2), .hp_left_on(hp_l), .hp_right_on(hp_r),
    .hp_bridged(hb), .hp_mono_sum(hs), .receiver_on(rcv),
    .headphone_left_gain(hgl), .headphone_right_gain(hgr),
    .speaker_left_on(spl), .speaker_right_on(spr), .switch_tick(tick),
    .speaker_left_gain(sgl), .speaker_right_gain(sgr),
    .line_out_left_on(lol), .line_out_right_on(lor),
    .line_output_left_gain(lgl), .line_output_right_gain(lgr),
    .vol_init_done(vdone));

  task automatic close_out;
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [7:0] a, exp);
    host.rd(a, rv);
    chk(rv, exp, "read data");
  endtask

  task automatic bound(input int n, lim);
    if (n >= lim) begin
      mismatches++;
      $display("wrong value at %0t: wait timed out", $time);
      close_out;
    end
  endtask

  // Decoded outputs trail a write by two cycles.
  task automatic settle;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic s_reset_adc;
    int n;
    n = 0;
    chk_rd(8'h01, 8'h00);
    chk(8'(vdone), 8'h00, "init early");
    while (vdone !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    bound(n, 40);
    chk_rd(CPM_CONV_OFS, 8'h00);
    host.wr(CPM_CONV_OFS, 8'hf0);
    settle;
    chk(8'({adl, adr}), 8'h03, "adc pair");
    chk_rd(CPM_CONV_OFS, 8'hf0);
    host.wr(CPM_CONV_OFS, 8'h10);
    settle;
    chk(8'({adl, adr}), 8'h01, "adc right");
  endtask

  task automatic s_dac_hp;
    for (int i = 0; i < 4; i++) begin
      host.wr(CPM_FILT_OFS, 8'(i * 4 + 3 - i));
      settle;
      chk(8'({hsl, hsr}), 8'(i * 4 + 3 - i), "hp select");
      chk(8'(bl), 8'(i == 0 ? 0 : 1 << (i - 1)), "band l");
      chk(8'(br), 8'(i == 3 ? 0 : 1 << (2 - i)), "band r");
    end
  endtask

  // Each entry: primary format, secondary format, filter bits, outcome.
  task automatic s_voice;
    logic [15:0] tv [8] = '{16'ha036, 16'hb037, 16'h0b35, 16'h0a34,
                            16'h3530, 16'hab36, 16'hb013, 16'hb025};
    foreach (tv[k]) begin
      host.wr(CPM_FMT1_OFS, {4'h0, tv[k][15:12]});
      host.wr(CPM_FMT2_OFS, {4'h0, tv[k][11:8]});
      host.wr(CPM_FILT_OFS, {2'h0, tv[k][5:4], 4'h0});
      settle;
      chk(8'({rvh, pvh, vbw}), 8'(tv[k][2:0]), "voice");
    end
  endtask

  task automatic s_outmode;
    logic [7:0] e;
    for (int i = 0; i < 32; i++) begin
      host.wr(CPM_OMODE_OFS, 8'(i));
      settle;
      case (3'(i))
        3'h4: e = 8'h0c;
        3'h6: e = 8'h0e;
        3'h5: e = 8'h08;
        3'h7: e = 8'h01;
        default: e = 8'h00;
      endcase
      chk(8'({hp_l, hp_r, hb, rcv}), e, "hp mode");
      chk(8'(hs), 8'(e[1] | e[0] | (e[3:2] == 2'h2)), "sum");
      chk(8'({spl, spr}), 8'(i >> 3), "speaker mode");
      chk(8'({lol, lor}), 8'h00, "line outs off");
    end
  endtask

  task automatic s_gain;
    logic [7:0] ofs [6] = '{CPM_LIN1_OFS, CPM_LIN2_OFS, CPM_HPL_OFS,
                            CPM_HPR_OFS, CPM_SPL_OFS, CPM_SPR_OFS};
    foreach (ofs[k]) begin
      host.wr(ofs[k], 8'hff);
      chk_rd(ofs[k], k < 2 ? 8'h1f : 8'h3f);
      host.wr(ofs[k], k < 2 ? 8'(17 + k) : 8'(33 + k));
    end
    settle;
    chk({3'h0, li1}, 8'h11, "line in 1");
    chk({3'h0, li2}, 8'h12, "line in 2");
    chk({2'h0, hgl}, 8'h23, "hp gain l");
    chk({2'h0, hgr}, 8'h24, "hp gain r");
    chk({2'h0, sgl}, 8'h25, "spk gain l");
    chk({2'h0, sgr}, 8'h26, "spk gain r");
    chk({2'h0, lgl}, 8'h25, "line out gain");
    chk({2'h0, lgr}, 8'h26, "line out gain r");
  endtask

  task automatic s_clip;
    @(posedge core_clk);
    clip_event <= 1'b1;
    @(posedge core_clk);
    clip_event <= 1'b0;
    #1;
    chk(8'(clip_f), 8'h01, "clip set");
    chk_rd(CPM_STATUS_OFS, 8'h80);
    fork
      host.wr(CPM_STATUS_OFS, 8'h80);
      begin
        @(posedge core_clk);
        clip_event <= 1'b1;
        @(posedge core_clk);
        clip_event <= 1'b0;
      end
    join
    settle;
    chk(8'(clip_f), 8'h01, "set beats clear");
    host.wr(CPM_STATUS_OFS, 8'h80);
    settle;
    chk(8'(clip_f), 8'h00, "clip clear");
  endtask

  task automatic s_switch;
    int n;
    n = 0;
    host.wr(CPM_OMODE_OFS, 8'h18);
    host.wr(CPM_PWR_OFS, 8'h01);
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 30);
    bound(n, 30);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 30);
    chk(8'(n), 8'h04, "tick period");
    host.wr(CPM_PWR_OFS, 8'h00);
    settle;
    n = 0;
    repeat (12) begin
      @(posedge core_clk);
      #1;
      n += int'(tick === 1'b1);
    end
    chk(8'(n), 8'h00, "tick stopped");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    rst_b = 1'b0;
    clip_event = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    s_reset_adc;
    s_dac_hp;
    s_voice;
    s_outmode;
    s_gain;
    s_clip;
    s_switch;
    close_out;
  end
endmodule
